// file: rtl/bdl_params.svh
// constants for the byte and doubleword load unit
`ifndef BDL_PARAMS_SVH
`define BDL_PARAMS_SVH
`define BDL_OP_HI 31
`define BDL_OP_LO 26
`define BDL_BASE_HI 25
`define BDL_BASE_LO 21
`define BDL_TGT_HI 20
`define BDL_TGT_LO 16
`define BDL_DISP_HI 15
`define BDL_OP_LBS 6'h20
`define BDL_OP_LBZ 6'h24
`define BDL_OP_LD 6'h37
`define BDL_OP_LDC_PFX 4'hd
`define BDL_CP_ZERO 2'h0
`define BDL_EXC_NONE 3'h0
`define BDL_EXC_ADDR 3'h1
`define BDL_EXC_REFILL 3'h2
`define BDL_EXC_INVALID 3'h3
`define BDL_EXC_CPU 3'h4
`define BDL_EXC_BUS 3'h5
`endif

// file: rtl/bdl_pkg.sv
// types shared by the load unit modules
package bdl_pkg;
    typedef enum logic [2:0] {
        BDL_K_NONE = 3'h0,
        BDL_K_BYTE_S = 3'h1,
        BDL_K_BYTE_Z = 3'h2,
        BDL_K_DW = 3'h3,
        BDL_K_DW_CP = 3'h4
    } bdl_kind_t;
    typedef enum logic [2:0] {
        BDL_S_IDLE = 3'b001,
        BDL_S_MEM = 3'b010,
        BDL_S_DONE = 3'b100
    } bdl_state_t;
endpackage : bdl_pkg

// file: rtl/bdl_dec_if.sv
// decoded instruction carried from the decoder to the load engine
interface bdl_dec_if;
    import bdl_pkg::*;
    bdl_kind_t kind;
    logic [4:0] base;
    logic [4:0] tgt;
    logic [1:0] cp_unit;
    logic [15:0] disp;
    modport src (output kind, base, tgt, cp_unit, disp);
    modport dst (input kind, base, tgt, cp_unit, disp);
endinterface : bdl_dec_if

// file: rtl/bdl_decoder.sv
// instruction word decoder for the load group
`include "bdl_params.svh"
module bdl_decoder import bdl_pkg::*; (
    // instruction
    input wire logic [31:0] instr,
    // decoded fields
    bdl_dec_if.src dec
);
    logic [5:0] op;
    always_comb begin
        op = instr[`BDL_OP_HI:`BDL_OP_LO];
        dec.base = instr[`BDL_BASE_HI:`BDL_BASE_LO];
        dec.tgt = instr[`BDL_TGT_HI:`BDL_TGT_LO];
        dec.disp = instr[`BDL_DISP_HI:0];
        dec.cp_unit = op[1:0];
        if (op == `BDL_OP_LBS) begin
            dec.kind = BDL_K_BYTE_S;
        end else if (op == `BDL_OP_LBZ) begin
            dec.kind = BDL_K_BYTE_Z;
        end else if (op == `BDL_OP_LD) begin
            dec.kind = BDL_K_DW;
        // the unit three code belongs to the plain doubleword load; unit zero is excluded
        end else if (op[5:2] == `BDL_OP_LDC_PFX && op[1:0] != `BDL_CP_ZERO) begin
            dec.kind = BDL_K_DW_CP;
        end else begin
            dec.kind = BDL_K_NONE;
        end
    end
endmodule : bdl_decoder

// file: rtl/bdl_lane.sv
// byte lane picker and extension
module bdl_lane (
    // inputs
    input wire logic [63:0] data,
    input wire logic [2:0] virtual_address_lo,
    input wire logic big_endian,
    input wire logic mode64,
    input wire logic sign_ext,
    // result
    output logic [63:0] result
);
    logic [2:0] lane;
    logic [7:0] b;
    always_comb begin
        if (mode64) begin
            lane = virtual_address_lo ^ {3{big_endian}};
        end else begin
            lane = {1'b0, virtual_address_lo[1:0] ^ {2{big_endian}}};
        end
        b = data[{lane, 3'b000} +: 8];
        if (sign_ext) begin
            result = {{56{b[7]}}, b};
        end else begin
            result = {56'h0000_0000_0000_00, b};
        end
    end
endmodule : bdl_lane

// file: rtl/bdl_load_unit.sv
// byte and doubleword load execution unit
`include "bdl_params.svh"
module bdl_load_unit import bdl_pkg::*; #(
    parameter int PADDR_W = 36
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // issue
    input wire logic issue_valid,
    input wire logic [31:0] issue_instr,
    output logic issue_ready_q,
    // mode
    input wire logic mode64,
    input wire logic processor_big_endian_flag,
    input wire logic reverse_byte_order_flag,
    input wire logic [3:0] cp_usable,
    // general register read
    output logic [4:0] gr_raddr_q,
    input wire logic [63:0] gr_rdata,
    // translation and memory
    output logic mem_req_q,
    output logic [63:0] mem_virtual_address_q,
    output logic mem_dw_q,
    output logic mem_rev_q,
    input wire logic mem_ack,
    input wire logic [PADDR_W-1:0] mem_paddr,
    input wire logic tlb_refill,
    input wire logic tlb_invalid,
    input wire logic bus_error,
    input wire logic [63:0] mem_rdata,
    output logic [PADDR_W-1:0] mem_paddr_q,
    // general register write
    output logic gr_we_q,
    output logic [4:0] gr_waddr_q,
    output logic [63:0] gr_wdata_q,
    // coprocessor delivery
    output logic cp_we_q,
    output logic [1:0] cp_unit_q,
    output logic [4:0] cp_reg_q,
    output logic [63:0] cp_data_q,
    // exceptions
    output logic exc_valid_q,
    output logic [2:0] exc_code_q,
    output logic done_q
);
    bdl_dec_if dec_bus();
    bdl_decoder u_dec (
        .instr(issue_instr),
        .dec(dec_bus)
    );

    // ==========================================
    // held request
    bdl_state_t st_q, st_d;
    bdl_kind_t kind_q, kind_d;
    logic [4:0] tgt_q, tgt_d;
    logic [1:0] unit_q, unit_d;
    logic [15:0] disp_q, disp_d;
    logic [63:0] ea;
    logic [63:0] lane_res;
    logic issue_ready_d, mem_req_d, mem_dw_d, mem_rev_d, gr_we_d, cp_we_d;
    logic exc_valid_d, done_d;
    logic [4:0] gr_raddr_d, gr_waddr_d, cp_reg_d;
    logic [63:0] mem_virtual_address_d, gr_wdata_d, cp_data_d;
    logic [2:0] exc_code_d;
    logic [1:0] cp_unit_d;
    logic [PADDR_W-1:0] mem_paddr_d;
    logic [2:0] early_code;

    function automatic logic [PADDR_W-1:0] flip_low(input logic [PADDR_W-1:0] pa,
                                                   input logic m64, input logic rev);
        logic [PADDR_W-1:0] r;
        r = pa;
        if (m64) begin
            r[2:0] = pa[2:0] ^ {3{rev}};
        end else begin
            r[1:0] = pa[1:0] ^ {2{rev}};
        end
        return r;
    endfunction : flip_low

    // both doubleword kinds share the alignment check and the full-width fetch
    function automatic logic is_dw(input bdl_kind_t k);
        return (k == BDL_K_DW) || (k == BDL_K_DW_CP);
    endfunction : is_dw

    // checked before translation; byte kinds never reach the alignment test
    function automatic logic [2:0] early_exc(input bdl_kind_t k, input logic usable,
                                             input logic [2:0] ea_lo);
        logic [2:0] code;
        code = `BDL_EXC_NONE;
        if (k == BDL_K_DW_CP && !usable) begin
            code = `BDL_EXC_CPU;
        end else if (is_dw(k) && ea_lo != 3'h0) begin
            code = `BDL_EXC_ADDR;
        end
        return code;
    endfunction : early_exc

    // refill wins over invalid, invalid over a bus fault
    function automatic logic [2:0] ack_exc(input logic refill, input logic invalid,
                                           input logic berr);
        logic [2:0] code;
        code = `BDL_EXC_NONE;
        if (refill) begin
            code = `BDL_EXC_REFILL;
        end else if (invalid) begin
            code = `BDL_EXC_INVALID;
        end else if (berr) begin
            code = `BDL_EXC_BUS;
        end
        return code;
    endfunction : ack_exc

    // the base register is read one cycle ahead; gr_rdata belongs to gr_raddr_q
    assign ea = gr_rdata + {{48{disp_q[`BDL_DISP_HI]}}, disp_q};
    assign early_code = early_exc(kind_q, cp_usable[unit_q], ea[2:0]);

    bdl_lane u_lane (
        .data(mem_rdata),
        .virtual_address_lo(mem_virtual_address_q[2:0]),
        .big_endian(processor_big_endian_flag),
        .mode64(mode64),
        .sign_ext(kind_q == BDL_K_BYTE_S),
        .result(lane_res)
    );

    // ==========================================
    // sequencer
    always_comb begin
        st_d = st_q;
        kind_d = kind_q;
        tgt_d = tgt_q;
        unit_d = unit_q;
        disp_d = disp_q;
        issue_ready_d = 1'b0;
        gr_raddr_d = gr_raddr_q;
        mem_req_d = 1'b0;
        mem_virtual_address_d = mem_virtual_address_q;
        mem_dw_d = mem_dw_q;
        mem_rev_d = mem_rev_q;
        case (st_q)
            BDL_S_IDLE: begin
                issue_ready_d = 1'b1;
                if (issue_valid && issue_ready_q) begin
                    issue_ready_d = 1'b0;
                    kind_d = dec_bus.kind;
                    tgt_d = dec_bus.tgt;
                    unit_d = dec_bus.cp_unit;
                    disp_d = dec_bus.disp;
                    gr_raddr_d = dec_bus.base;
                    st_d = BDL_S_MEM;
                end
            end
            BDL_S_MEM: begin
                mem_virtual_address_d = ea;
                mem_dw_d = is_dw(kind_q);
                mem_rev_d = reverse_byte_order_flag;
                // early exceptions and unknown codes finish here, nothing goes to memory
                if (kind_q == BDL_K_NONE || early_code != `BDL_EXC_NONE) begin
                    st_d = BDL_S_IDLE;
                end else begin
                    mem_req_d = 1'b1;
                    st_d = BDL_S_DONE;
                end
            end
            BDL_S_DONE: begin
                mem_req_d = 1'b1;
                if (mem_ack) begin
                    mem_req_d = 1'b0;
                    st_d = BDL_S_IDLE;
                end
            end
            default: begin
                st_d = BDL_S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= BDL_S_IDLE;
            kind_q <= BDL_K_NONE;
            tgt_q <= 5'h00;
            unit_q <= 2'h0;
            disp_q <= 16'h0000;
            issue_ready_q <= 1'b0;
            gr_raddr_q <= 5'h00;
            mem_req_q <= 1'b0;
            mem_virtual_address_q <= 64'h0000_0000_0000_0000;
            mem_dw_q <= 1'b0;
            mem_rev_q <= 1'b0;
        end else begin
            st_q <= st_d;
            kind_q <= kind_d;
            tgt_q <= tgt_d;
            unit_q <= unit_d;
            disp_q <= disp_d;
            issue_ready_q <= issue_ready_d;
            gr_raddr_q <= gr_raddr_d;
            mem_req_q <= mem_req_d;
            mem_virtual_address_q <= mem_virtual_address_d;
            mem_dw_q <= mem_dw_d;
            mem_rev_q <= mem_rev_d;
        end
    end

    // ==========================================
    // results
    always_comb begin
        mem_paddr_d = mem_paddr_q;
        gr_we_d = 1'b0;
        gr_waddr_d = gr_waddr_q;
        gr_wdata_d = gr_wdata_q;
        cp_we_d = 1'b0;
        cp_unit_d = cp_unit_q;
        cp_reg_d = cp_reg_q;
        cp_data_d = cp_data_q;
        exc_valid_d = 1'b0;
        exc_code_d = `BDL_EXC_NONE;
        done_d = 1'b0;
        case (st_q)
            BDL_S_MEM: begin
                if (kind_q == BDL_K_NONE) begin
                    done_d = 1'b1;
                end else if (early_code != `BDL_EXC_NONE) begin
                    exc_valid_d = 1'b1;
                    exc_code_d = early_code;
                    done_d = 1'b1;
                end
            end
            BDL_S_DONE: begin
                if (mem_ack) begin
                    done_d = 1'b1;
                    mem_paddr_d = mem_dw_q ? mem_paddr
                                           : flip_low(mem_paddr, mode64, mem_rev_q);
                    exc_code_d = ack_exc(tlb_refill, tlb_invalid, bus_error);
                    if (exc_code_d != `BDL_EXC_NONE) begin
                        exc_valid_d = 1'b1;
                    end else if (kind_q == BDL_K_DW_CP) begin
                        cp_we_d = 1'b1;
                        cp_unit_d = unit_q;
                        cp_reg_d = tgt_q;
                        cp_data_d = mem_rdata;
                    end else begin
                        gr_we_d = 1'b1;
                        gr_waddr_d = tgt_q;
                        gr_wdata_d = (kind_q == BDL_K_DW) ? mem_rdata : lane_res;
                    end
                end
            end
            default: begin
                done_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mem_paddr_q <= '0;
            gr_we_q <= 1'b0;
            gr_waddr_q <= 5'h00;
            gr_wdata_q <= 64'h0000_0000_0000_0000;
            cp_we_q <= 1'b0;
            cp_unit_q <= 2'h0;
            cp_reg_q <= 5'h00;
            cp_data_q <= 64'h0000_0000_0000_0000;
            exc_valid_q <= 1'b0;
            exc_code_q <= `BDL_EXC_NONE;
            done_q <= 1'b0;
        end else begin
            mem_paddr_q <= mem_paddr_d;
            gr_we_q <= gr_we_d;
            gr_waddr_q <= gr_waddr_d;
            gr_wdata_q <= gr_wdata_d;
            cp_we_q <= cp_we_d;
            cp_unit_q <= cp_unit_d;
            cp_reg_q <= cp_reg_d;
            cp_data_q <= cp_data_d;
            exc_valid_q <= exc_valid_d;
            exc_code_q <= exc_code_d;
            done_q <= done_d;
        end
    end
endmodule : bdl_load_unit

// file: verification/bdl_load_unit_asserts.sv
// port checks for the load unit
module bdl_load_unit_asserts #(
    parameter int PADDR_W = 36
) (
    // clock and mode
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic mode64,
    // memory side
    input wire logic mem_req_q,
    input wire logic [63:0] mem_virtual_address_q,
    input wire logic mem_dw_q,
    input wire logic mem_rev_q,
    input wire logic mem_ack,
    input wire logic [PADDR_W-1:0] mem_paddr,
    input wire logic tlb_refill,
    input wire logic tlb_invalid,
    input wire logic bus_error,
    input wire logic [63:0] mem_rdata,
    input wire logic [PADDR_W-1:0] mem_paddr_q,
    // results
    input wire logic gr_we_q,
    input wire logic [63:0] gr_wdata_q,
    input wire logic cp_we_q,
    input wire logic [63:0] cp_data_q,
    input wire logic exc_valid_q,
    input wire logic [2:0] exc_code_q,
    input wire logic done_q
);
    timeunit 1ns;
    timeprecision 1ns;
    logic ok;
    // ====================
    // clean acknowledge
    assign ok = mem_req_q && mem_ack && !tlb_refill && !tlb_invalid && !bus_error;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_align; mem_req_q |-> !mem_dw_q || mem_virtual_address_q[2:0] == 3'h0; endproperty
    a_align: assert property (p_align) else $error("misaligned doubleword sent");
    property p_refill; mem_req_q && mem_ack && tlb_refill |=> exc_valid_q && exc_code_q == 3'h2;
    endproperty
    a_refill: assert property (p_refill) else $error("refill not raised");
    property p_inval;
        mem_req_q && mem_ack && !tlb_refill && tlb_invalid |=> exc_valid_q && exc_code_q == 3'h3;
    endproperty
    a_inval: assert property (p_inval) else $error("invalid not raised");
    property p_dw; ok && mem_dw_q |=> (gr_we_q && gr_wdata_q == $past(mem_rdata))
        || (cp_we_q && cp_data_q == $past(mem_rdata)); endproperty
    a_dw: assert property (p_dw) else $error("doubleword altered");
    property p_ext; gr_we_q && !$past(mem_dw_q) |-> gr_wdata_q[63:8] == '0 || &gr_wdata_q[63:7];
    endproperty
    a_ext: assert property (p_ext) else $error("byte extension wrong");
    property p_rev64; ok && !mem_dw_q && mode64 |=>
        mem_paddr_q[2:0] == ($past(mem_paddr[2:0]) ^ {3{$past(mem_rev_q)}}); endproperty
    a_rev64: assert property (p_rev64) else $error("64-bit byte address wrong");
    property p_rev32; ok && !mem_dw_q && !mode64 |=> mem_paddr_q[2] == $past(mem_paddr[2])
        && mem_paddr_q[1:0] == ($past(mem_paddr[1:0]) ^ {2{$past(mem_rev_q)}}); endproperty
    a_rev32: assert property (p_rev32) else $error("32-bit byte address wrong");
    property p_byte; ok && !mem_dw_q |=> gr_we_q && !exc_valid_q; endproperty
    a_byte: assert property (p_byte) else $error("byte load not written");
    property p_exc; exc_valid_q |-> done_q && !gr_we_q && !cp_we_q; endproperty
    a_exc: assert property (p_exc) else $error("write beside exception");
endmodule : bdl_load_unit_asserts

bind bdl_load_unit bdl_load_unit_asserts #(.PADDR_W(PADDR_W)) u_asserts (
    .clk, .sys_rst, .mode64, .mem_req_q, .mem_virtual_address_q, .mem_dw_q, .mem_rev_q, .mem_ack,
    .mem_paddr, .tlb_refill, .tlb_invalid, .bus_error, .mem_rdata, .mem_paddr_q, .gr_we_q,
    .gr_wdata_q, .cp_we_q, .cp_data_q, .exc_valid_q, .exc_code_q, .done_q
);

// file: verification/bdl_mem_model.sv
// register file, translation and memory answering the load unit
module bdl_mem_model #(
    parameter int PADDR_W = 36
) (
    // clock and requests
    input wire logic clk,
    input wire logic [4:0] gr_raddr_q,
    input wire logic mem_req_q,
    input wire logic [63:0] mem_virtual_address_q,
    // scenario control
    input wire logic [1:0] fault,
    input wire logic [1:0] delay,
    // answers
    output logic [63:0] gr_rdata,
    output logic mem_ack,
    output logic [PADDR_W-1:0] mem_paddr,
    output logic tlb_refill,
    output logic tlb_invalid,
    output logic bus_error,
    output logic [63:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] wait_q;
    logic [63:0] pat;
    // ====================
    // low base bits follow the register number so some bases are misaligned
    assign gr_rdata = {8{gr_raddr_q, gr_raddr_q[2:0]}};
    assign pat = {3'h5, mem_virtual_address_q[31:3], 3'h2, ~mem_virtual_address_q[31:3]};
    // lines show inverted values outside the answer cycle, never stale ones
    assign mem_rdata = mem_ack ? pat : ~pat;
    assign mem_paddr = mem_ack ? mem_virtual_address_q[PADDR_W-1:0] : ~mem_virtual_address_q[PADDR_W-1:0];
    assign tlb_refill = mem_ack && fault == 2'h1;
    assign tlb_invalid = mem_ack && fault == 2'h2;
    assign bus_error = mem_ack && fault == 2'h3;
    initial begin
        mem_ack = 1'b0;
        wait_q = 2'h0;
    end
    always @(posedge clk) begin
        mem_ack <= 1'b0;
        if (mem_req_q && !mem_ack) begin
            if (wait_q == 2'h0) begin
                mem_ack <= 1'b1;
                wait_q <= delay;
            end else begin
                wait_q <= wait_q - 2'h1;
            end
        end
    end
endmodule : bdl_mem_model

// file: verification/bdl_load_unit_test.sv
// self-checking bench for the load unit
`include "bdl_params.svh"
module bdl_load_unit_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, sys_rst, issue_valid, issue_ready_q, mode64, mem_req_q, mem_dw_q, mem_rev_q;
    logic processor_big_endian_flag, reverse_byte_order_flag, mem_ack, tlb_refill, tlb_invalid;
    logic bus_error, gr_we_q, cp_we_q, exc_valid_q, done_q;
    logic [31:0] issue_instr, ins;
    logic [3:0] cp_usable;
    logic [4:0] gr_raddr_q, gr_waddr_q, cp_reg_q;
    logic [63:0] gr_rdata, mem_virtual_address_q, mem_rdata, gr_wdata_q, cp_data_q;
    logic [35:0] mem_paddr, mem_paddr_q;
    logic [1:0] cp_unit_q, fault, delay;
    logic [2:0] exc_code_q;
    logic [5:0] op;
    logic [5:0] ops [6];
    logic [8:0] cfg;
    logic [79:0] obs, expv;
    logic [79:0] notes [$];
    int err_count, samples_checked;
    bdl_load_unit #(.PADDR_W(36)) dut (.clk, .sys_rst, .issue_valid, .issue_instr, .issue_ready_q,
        .mode64, .processor_big_endian_flag, .reverse_byte_order_flag, .cp_usable, .gr_raddr_q,
        .gr_rdata, .mem_req_q, .mem_virtual_address_q, .mem_dw_q, .mem_rev_q, .mem_ack, .mem_paddr,
        .tlb_refill, .tlb_invalid, .bus_error, .mem_rdata, .mem_paddr_q, .gr_we_q, .gr_waddr_q,
        .gr_wdata_q, .cp_we_q, .cp_unit_q, .cp_reg_q, .cp_data_q, .exc_valid_q, .exc_code_q,
        .done_q);
    bdl_mem_model #(.PADDR_W(36)) u_mem (.clk, .gr_raddr_q, .mem_req_q, .mem_virtual_address_q, .fault,
        .delay, .gr_rdata, .mem_ack, .mem_paddr, .tlb_refill, .tlb_invalid, .bus_error, .mem_rdata);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ====================
    // expected result: {gr, cp, exc, code, unit, reg, paddr low, data}
    // cfg is {mode64, big endian, reverse, usable[3:0], fault}
    function automatic logic [79:0] expect_of(input logic [31:0] i, input logic [8:0] c);
        logic [63:0] ea, pat;
        logic [7:0] b;
        logic [5:0] o;
        logic [2:0] lo, pa, fc;
        logic cpo;
        o = i[31:26];
        ea = {8{i[25:21], i[23:21]}} + {{48{i[15]}}, i[15:0]};
        pat = {3'h5, ea[31:3], 3'h2, ~ea[31:3]};
        lo = c[8] ? ea[2:0] ^ {3{c[7]}} : {1'b0, ea[1:0] ^ {2{c[7]}}};
        pa = c[8] ? ea[2:0] ^ {3{c[6]}} : {ea[2], ea[1:0] ^ {2{c[6]}}};
        b = pat[8*lo +: 8];
        fc = c[1:0] == 2'h3 ? 3'h5 : {1'b0, c[1:0]} + 3'h1;
        cpo = o[5:2] == `BDL_OP_LDC_PFX && o[1:0] != 2'h0 && o != `BDL_OP_LD;
        if (o == `BDL_OP_LBS || o == `BDL_OP_LBZ) begin
            if (c[1:0] != 2'h0) return {3'h1, fc, 74'h0};
            return {3'h4, 5'h0, i[20:16], pa, o == `BDL_OP_LBS ? {{56{b[7]}}, b} : {56'h0, b}};
        end
        if (cpo && !c[2 + o[1:0]]) return {3'h1, 3'h4, 74'h0};
        if (!cpo && o != `BDL_OP_LD) return 80'h0;
        if (ea[2:0] != 3'h0) return {3'h1, 3'h1, 74'h0};
        if (c[1:0] != 2'h0) return {3'h1, fc, 74'h0};
        return {cpo ? 3'h2 : 3'h4, 3'h0, cpo ? o[1:0] : 2'h0, i[20:16], 3'h0, pat};
    endfunction : expect_of
    task automatic run_op(input logic [31:0] i, input logic [8:0] c);
        int n;
        n = 0;
        @(negedge clk);
        while (issue_ready_q !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        issue_instr = i;
        {mode64, processor_big_endian_flag, reverse_byte_order_flag, cp_usable, fault} = c;
        notes.push_back(expect_of(i, c));
        issue_valid = 1'b1;
        @(negedge clk);
        issue_valid = 1'b0;
        while (done_q !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        if (done_q !== 1'b1) begin
            err_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, 1'b1, done_q);
        end
        $display("test %h cfg %h ended", i, c);
    endtask : run_op
    task automatic end_sim;
        $display("compared %0d mismatched %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    // ====================
    // result watcher: one note per finished instruction
    always @(negedge clk) begin
        if (done_q === 1'b1) begin
            obs = {gr_we_q, cp_we_q, exc_valid_q, exc_valid_q ? exc_code_q : 3'h0,
                cp_we_q ? cp_unit_q : 2'h0, gr_we_q ? gr_waddr_q : cp_we_q ? cp_reg_q : 5'h0,
                gr_we_q ? mem_paddr_q[2:0] : 3'h0, gr_we_q ? gr_wdata_q : cp_we_q ? cp_data_q : 64'h0};
            expv = notes.size() > 0 ? notes.pop_front() : '1;
            samples_checked++;
            if (obs !== expv) begin
                err_count++;
                $display("MISMATCH t=%0t exp=%h got=%h", $time, expv, obs);
            end
        end
    end
    initial begin
        #100_000;
        err_count++;
        end_sim();
    end
    initial begin
        {issue_valid, mode64, processor_big_endian_flag, reverse_byte_order_flag} = 4'h0;
        issue_instr = 32'h0000_0000;
        {cp_usable, fault, delay} = 8'h00;
        err_count = 0;
        samples_checked = 0;
        ops = '{`BDL_OP_LBS, `BDL_OP_LBZ, `BDL_OP_LD, 6'h35, 6'h36, 6'h34};
        sys_rst = 1'b1;
        repeat (5) @(negedge clk);
        sys_rst = 1'b0;
        void'($urandom(16434));
        run_op({`BDL_OP_LBS, 10'h3e3, 16'h8000}, 9'h180);
        run_op({`BDL_OP_LBZ, 10'h0e4, 16'hffff}, 9'h140);
        run_op({`BDL_OP_LBS, 10'h0a9, 16'h0007}, 9'h0c1);
        run_op({`BDL_OP_LBZ, 10'h125, 16'h0006}, 9'h040);
        run_op({`BDL_OP_LBS, 10'h125, 16'h0001}, 9'h102);
        run_op({`BDL_OP_LD, 10'h302, 16'h0010}, 9'h100);
        run_op({`BDL_OP_LD, 10'h0a2, 16'h0008}, 9'h101);
        run_op({`BDL_OP_LD, 10'h302, 16'h0000}, 9'h103);
        run_op({`BDL_OP_LDC_PFX, 2'h1, 10'h302, 16'h0018}, 9'h108);
        run_op({`BDL_OP_LDC_PFX, 2'h2, 10'h0a2, 16'h0000}, 9'h108);
        run_op({`BDL_OP_LDC_PFX, 2'h1, 10'h0a2, 16'h0000}, 9'h108);
        run_op({`BDL_OP_LDC_PFX, 2'h0, 10'h302, 16'h0000}, 9'h13c);
        run_op(32'h0000_0000, 9'h000);
        repeat (40) begin
            op = ops[$urandom_range(5)];
            ins = {op, 10'($urandom), 16'($urandom)};
            cfg = 9'($urandom);
            if (op[5:2] == `BDL_OP_LDC_PFX) begin
                ins[2:0] = 3'h0;
                cfg[8] = 1'b1;
            end
            cfg[5:2] = cfg[5:2] & 4'h6;
            if (cfg[1:0] == 2'h3) cfg[1:0] = 2'h0;
            delay = 2'($urandom);
            run_op(ins, cfg);
        end
        // let the watcher take the last result before counting what is left
        repeat (2) @(negedge clk);
        if (notes.size() != 0) begin
            err_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, 32'h0, notes.size());
        end
        end_sim();
    end
endmodule : bdl_load_unit_test
